// ---- verilog/rbm_ctrl.sv ----
// Receive blanking timer and modulator/clock-output control with APB register access
//
// The APB slave port was chosen for this implementation.
`timescale 1ns/100ps
`default_nettype none
`include "rbm_consts.svh"

// Functional notes
// - Blanking register loads 0x1F at reset and while disabled; protocol writes load the family preset.
// - After transmit ends, receive decoders stay in reset for the blanking interval.
// - Each blanking count lasts 9.44 us; values 1 to 255 span up to 2407 us.
// - Blanking interval starts at the end of the transmitted end-of-frame.
// - Protocol writes preset blanking: 9.44 us card212, 66 us 14443, 293 us 15693.
// - Modulator register resets to 0x11; protocol writes keep both clock-select bits.
// - Clock output is oscillator divided by 4, 2, 1 for codes 01, 10, 11; 00 off.
// - Clock-output select is bits 5:4 of modulator register, bit 5 most significant.
// - Bits 2:0 select modulation type and depth, ASK 7% to 30% or OOK.
// - External pin selects modulation only if both external-select bits are set.
// - With external selection, pin high requests OOK, low the preset ASK depth.
// - With external selection, modulation signal comes from the modulation input pin.
// - Analog-test bit turns the ASK/OOK pin into an analog subcarrier output.
// - Blanking register is one 8-bit count, bit 7 most significant.
// - Depth codes: 000 10%, 001 OOK, 010 7%, 011 8.5%, 100 13%, 101 16%, 110 22%, 111 30%.
module rbm_ctrl (
  input wire logic system_clock_output_in,
  input wire logic nrst_in,
  input wire logic ce_in,
  input wire logic [7:0] paddr_in,
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [31:0] pwdata_in,
  input wire logic chip_enable_in,
  input wire logic tx_eof_end_in,
  input wire logic tx_mod_in,
  input wire logic ask_ook_pin_in,
  input wire logic modulation_input_pin_in,
  input wire logic analog_subcarrier_in,
  output logic [31:0] prdata_out,
  output logic pready_out,
  output logic pslverr_out,
  output logic rx_decoder_reset_out,
  output logic system_clock_output_out,
  output logic ask_ook_pin_out,
  output logic ask_ook_pin_oe_out,
  output logic [2:0] mod_depth_out,
  output logic ook_active_out,
  output logic mod_signal_out
);

  localparam logic [7:0] STEP_LAST = 8'(`RBM_BLANK_STEP_CYC - 1);

  localparam rbm_pkg::rbm_state_t RST_STATE = '{
    st: rbm_pkg::RBM_ST_IDLE,
    blank_time: `RBM_BLANK_RST,
    modctl: `RBM_MODCTL_RST,
    proto: `RBM_PROTO_RST,
    count: 8'h00,
    step: 8'h00,
    div: 3'h0,
    en_sync: 2'h0,
    ook_sync: 2'h0,
    modp_sync: 2'h0,
    ana_sync: 2'h0,
    pready: 1'b0,
    pslverr: 1'b0,
    prdata: 32'h00000000,
    rx_rst: 1'b0,
    sysclk: 1'b0,
    ook_oe: 1'b0,
    ook_o: 1'b0,
    mod_sig: 1'b0,
    depth: 3'h0,
    ook_sel: 1'b0
  };

  rbm_pkg::rbm_state_t s;
  rbm_pkg::rbm_state_t next_s;

  logic apb_setup;
  logic apb_done;
  logic wr_proto;
  logic wr_blank;
  logic wr_modctl;
  logic ext_sel;

  // Byte address of a register index
  function automatic logic [7:0] reg_addr(input logic [5:0] idx);
    reg_addr = {idx, 2'b00};
  endfunction

  // Blanking preset from the protocol family field
  function automatic logic [7:0] blank_preset(input logic [1:0] fam);
    case (fam)
      `RBM_FAM_CARD212: blank_preset = 8'(`RBM_PRESET_CNT(`RBM_PRESET_CARD212_NS));
      `RBM_FAM_PROX_A: blank_preset = 8'(`RBM_PRESET_CNT(`RBM_PRESET_PROX_NS));
      `RBM_FAM_PROX_B: blank_preset = 8'(`RBM_PRESET_CNT(`RBM_PRESET_PROX_NS));
      default: blank_preset = 8'(`RBM_PRESET_CNT(`RBM_PRESET_VICINITY_NS));
    endcase
  endfunction

  always_comb begin
    next_s = s;
    next_s.pready = 1'b0;
    next_s.pslverr = 1'b0;
    next_s.en_sync = {s.en_sync[0], chip_enable_in};
    next_s.ook_sync = {s.ook_sync[0], ask_ook_pin_in};
    next_s.modp_sync = {s.modp_sync[0], modulation_input_pin_in};
    next_s.ana_sync = {s.ana_sync[0], analog_subcarrier_in};

    // Read data is captured in the setup cycle and held through the access phase
    apb_setup = psel_in && !penable_in && !s.pready;
    apb_done = psel_in && penable_in && s.pready;
    wr_proto = apb_done && pwrite_in && paddr_in == reg_addr(`RBM_IDX_PROTO);
    wr_blank = apb_done && pwrite_in && paddr_in == reg_addr(`RBM_IDX_BLANK);
    wr_modctl = apb_done && pwrite_in && paddr_in == reg_addr(`RBM_IDX_MODCTL);
    if (apb_setup) begin
      next_s.pready = 1'b1;
      next_s.prdata = 32'h00000000;
      if (paddr_in == reg_addr(`RBM_IDX_PROTO)) begin
        next_s.prdata[7:0] = s.proto;
      end else if (paddr_in == reg_addr(`RBM_IDX_BLANK)) begin
        next_s.prdata[7:0] = s.blank_time;
      end else if (paddr_in == reg_addr(`RBM_IDX_MODCTL)) begin
        next_s.prdata[7:0] = s.modctl & `RBM_MOD_USED_MASK;
      end else if (paddr_in == reg_addr(`RBM_IDX_STATUS)) begin
        next_s.prdata[15:0] = {s.count, 6'h00, s.st == rbm_pkg::RBM_ST_BLANK, ext_sel_now(s)};
      end else begin
        next_s.pslverr = 1'b1;
      end
    end

    // Register writes
    if (wr_blank) begin
      next_s.blank_time = pwdata_in[7:0];
    end
    if (wr_modctl) begin
      next_s.modctl = pwdata_in[7:0] & `RBM_MOD_USED_MASK;
    end
    if (wr_proto) begin
      next_s.proto = pwdata_in[7:0];
      next_s.blank_time = blank_preset(pwdata_in[`RBM_PROTO_FAM_HI:`RBM_PROTO_FAM_LO]);
      next_s.modctl = `RBM_MODCTL_RST;
      next_s.modctl[`RBM_MOD_CLK_HI:`RBM_MOD_CLK_LO] = s.modctl[`RBM_MOD_CLK_HI:`RBM_MOD_CLK_LO];
    end

    // Blanking timer; a new end-of-frame restarts it, or ends it if the blanking register is zero
    case (s.st)
      rbm_pkg::RBM_ST_IDLE: begin
        if (tx_eof_end_in && s.blank_time != 8'h00) begin
          next_s.st = rbm_pkg::RBM_ST_BLANK;
          next_s.count = s.blank_time;
          next_s.step = STEP_LAST;
        end
      end
      rbm_pkg::RBM_ST_BLANK: begin
        if (tx_eof_end_in) begin
          if (s.blank_time == 8'h00) begin
            next_s.st = rbm_pkg::RBM_ST_IDLE;
            next_s.count = 8'h00;
          end else begin
            next_s.count = s.blank_time;
            next_s.step = STEP_LAST;
          end
        end else if (s.step == 8'h00) begin
          if (s.count <= 8'h01) begin
            next_s.st = rbm_pkg::RBM_ST_IDLE;
            next_s.count = 8'h00;
          end else begin
            next_s.count = s.count - 8'h01;
            next_s.step = STEP_LAST;
          end
        end else begin
          next_s.step = s.step - 8'h01;
        end
      end
      default: begin
        next_s.st = rbm_pkg::RBM_ST_IDLE;
        next_s.count = 8'h00;
      end
    endcase

    // Chip disabled: registers and blanking timer back to defaults, decoders released
    if (!s.en_sync[1]) begin
      next_s.blank_time = `RBM_BLANK_RST;
      next_s.modctl = `RBM_MODCTL_RST;
      next_s.proto = `RBM_PROTO_RST;
      next_s.st = rbm_pkg::RBM_ST_IDLE;
      next_s.count = 8'h00;
      next_s.step = 8'h00;
    end
    next_s.rx_rst = next_s.st == rbm_pkg::RBM_ST_BLANK;

    // Clock output; the oscillator is modelled at half the bus clock, so /1 toggles every cycle
    next_s.div = s.div + 3'h1;
    case (next_s.modctl[`RBM_MOD_CLK_HI:`RBM_MOD_CLK_LO])
      `RBM_CLK_DIV4: next_s.sysclk = next_s.div[2];
      `RBM_CLK_DIV2: next_s.sysclk = next_s.div[1];
      `RBM_CLK_DIV1: next_s.sysclk = next_s.div[0];
      default: next_s.sysclk = 1'b0;
    endcase

    // Modulation select; the pin cannot both drive analog out and select OOK
    ext_sel = ext_sel_now(next_s);
    if (ext_sel && next_s.ook_sync[1]) begin
      next_s.depth = `RBM_DEPTH_OOK;
    end else begin
      next_s.depth = next_s.modctl[`RBM_MOD_DEPTH_HI:`RBM_MOD_DEPTH_LO];
    end
    next_s.ook_sel = next_s.depth == `RBM_DEPTH_OOK;
    next_s.mod_sig = ext_sel ? next_s.modp_sync[1] : tx_mod_in;
    next_s.ook_oe = next_s.modctl[`RBM_MOD_ANA_BIT];
    next_s.ook_o = next_s.modctl[`RBM_MOD_ANA_BIT] && next_s.ana_sync[1];
  end

  // External selection is live only with both enables and no analog test
  function automatic logic ext_sel_now(input rbm_pkg::rbm_state_t st);
    ext_sel_now = st.modctl[`RBM_MOD_EXT_BIT] && st.proto[`RBM_PROTO_EXT_BIT] && !st.modctl[`RBM_MOD_ANA_BIT];
  endfunction

  always_ff @(posedge system_clock_output_in or negedge nrst_in) begin
    if (!nrst_in) begin
      s <= RST_STATE;
    end else if (ce_in) begin
      s <= next_s;
    end
  end

  assign prdata_out = s.prdata;
  assign pready_out = s.pready;
  assign pslverr_out = s.pslverr;
  assign rx_decoder_reset_out = s.rx_rst;
  assign system_clock_output_out = s.sysclk;
  assign ask_ook_pin_out = s.ook_o;
  assign ask_ook_pin_oe_out = s.ook_oe;
  assign mod_depth_out = s.depth;
  assign ook_active_out = s.ook_sel;
  assign mod_signal_out = s.mod_sig;

  // Checks
  default clocking cb @(posedge system_clock_output_in);
  endclocking
  default disable iff (!nrst_in);

  sequence seq_proto_write;
    ce_in && s.en_sync[1] && psel_in && penable_in && s.pready && pwrite_in
      && paddr_in == reg_addr(`RBM_IDX_PROTO);
  endsequence

  sequence seq_eof_load;
    ce_in && s.en_sync[1] && tx_eof_end_in && s.blank_time != 8'h00;
  endsequence

  chk_blank_disable_val: assert property (ce_in && !s.en_sync[1] |=> s.blank_time == `RBM_BLANK_RST)
    else $error("blanking register not at default while disabled");
  chk_blank_hold_eof: assert property (seq_eof_load |=> rx_decoder_reset_out ##0 s.count == $past(s.blank_time))
    else $error("decoders not held after end of frame");
  chk_blank_step_dec: assert property (ce_in && s.en_sync[1] && !tx_eof_end_in && s.st == rbm_pkg::RBM_ST_BLANK
      && s.step == 8'h00 && s.count > 8'h01 |=> s.count == $past(s.count) - 8'h01 && s.step == STEP_LAST)
    else $error("blanking count step wrong");
  chk_blank_preset_val: assert property (seq_proto_write |=> s.blank_time == blank_preset($past(pwdata_in[1:0])))
    else $error("blanking preset wrong");
  chk_modctl_keep_clk: assert property (seq_proto_write |=> s.modctl[5:4] == $past(s.modctl[5:4])
      && s.modctl[3:0] == 4'h1 && s.modctl[7:6] == 2'h0)
    else $error("modulator register preset wrong");
  chk_clk_out_off: assert property (ce_in && next_s.modctl[5:4] == `RBM_CLK_OFF |=> !system_clock_output_out)
    else $error("clock output not disabled");
  chk_ext_pin_ook: assert property (ce_in && ext_sel && next_s.ook_sync[1] |=> ook_active_out && mod_depth_out == 3'h1)
    else $error("external OOK request ignored");
  chk_int_depth_sel: assert property (ce_in && !ext_sel |=> mod_depth_out == $past(next_s.modctl[2:0]))
    else $error("depth does not follow register");
  chk_ana_pin_out: assert property (ce_in && next_s.modctl[3] |=> ask_ook_pin_oe_out)
    else $error("analog test output not enabled");
  chk_zero_release: assert property (ce_in && s.en_sync[1] && tx_eof_end_in && s.blank_time == 8'h00
      |=> !rx_decoder_reset_out)
    else $error("zero blanking still holds decoders");

endmodule
`default_nettype wire

// ---- include/rbm_consts.svh ----
// Register map, field positions, reset values and timing counts for the blanking/modulator block
`ifndef RBM_CONSTS_SVH
`define RBM_CONSTS_SVH

// Register indices; byte address is four times the index
`define RBM_IDX_PROTO 6'h01
`define RBM_IDX_BLANK 6'h08
`define RBM_IDX_MODCTL 6'h09
`define RBM_IDX_STATUS 6'h10

// Reset values
`define RBM_BLANK_RST 8'h1F
`define RBM_MODCTL_RST 8'h11
`define RBM_PROTO_RST 8'h00

// Modulator control fields
`define RBM_MOD_EXT_BIT 6
`define RBM_MOD_CLK_HI 5
`define RBM_MOD_CLK_LO 4
`define RBM_MOD_ANA_BIT 3
`define RBM_MOD_DEPTH_HI 2
`define RBM_MOD_DEPTH_LO 0
`define RBM_MOD_USED_MASK 8'h7F
`define RBM_DEPTH_OOK 3'h1

// Protocol select fields
`define RBM_PROTO_EXT_BIT 6
`define RBM_PROTO_FAM_HI 1
`define RBM_PROTO_FAM_LO 0
`define RBM_FAM_VICINITY 2'h0
`define RBM_FAM_PROX_A 2'h1
`define RBM_FAM_CARD212 2'h2
`define RBM_FAM_PROX_B 2'h3

// Clock output select codes
`define RBM_CLK_OFF 2'h0
`define RBM_CLK_DIV4 2'h1
`define RBM_CLK_DIV2 2'h2
`define RBM_CLK_DIV1 2'h3

// Timing
`define RBM_CLK_PERIOD_NS 40
`define RBM_BLANK_STEP_NS 9440
`define RBM_BLANK_STEP_CYC (`RBM_BLANK_STEP_NS / `RBM_CLK_PERIOD_NS)
`define RBM_PRESET_CARD212_NS 9440
`define RBM_PRESET_PROX_NS 66000
`define RBM_PRESET_VICINITY_NS 293000
`define RBM_PRESET_CNT(ns) (((ns) + (`RBM_BLANK_STEP_NS / 2)) / `RBM_BLANK_STEP_NS)

`endif

// ---- include/rbm_pkg.sv ----
// Types shared by the blanking/modulator block
`include "rbm_consts.svh"

package rbm_pkg;

  typedef enum logic [1:0] {
    RBM_ST_IDLE = 2'b01,
    RBM_ST_BLANK = 2'b10
  } rbm_blank_st_t;

  typedef struct packed {
    rbm_blank_st_t st;
    logic [7:0] blank_time;
    logic [7:0] modctl;
    logic [7:0] proto;
    logic [7:0] count;
    logic [7:0] step;
    logic [2:0] div;
    logic [1:0] en_sync;
    logic [1:0] ook_sync;
    logic [1:0] modp_sync;
    logic [1:0] ana_sync;
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
    logic rx_rst;
    logic sysclk;
    logic ook_oe;
    logic ook_o;
    logic mod_sig;
    logic [2:0] depth;
    logic ook_sel;
  } rbm_state_t;

endpackage

// ---- test/rbm_host_model.sv ----
// Host-side model of the ASK/OOK and modulation pins that the controller samples
`timescale 1ns/100ps
`default_nettype none
module rbm_host_model (
  input wire logic clk_in,
  input wire logic nrst_in,
  input wire logic req_ook_in,
  input wire logic mod_level_in,
  input wire logic dev_oe_in,
  output logic ook_pin_out,
  output logic ook_pin_oe_out,
  output logic mod_pin_out
);
  // Host lets go of the pin one clock after the device starts driving it
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      ook_pin_out <= 1'b0;
      ook_pin_oe_out <= 1'b0;
      mod_pin_out <= 1'b0;
    end else begin
      ook_pin_oe_out <= !dev_oe_in;
      ook_pin_out <= req_ook_in;
      mod_pin_out <= mod_level_in;
    end
  end
endmodule
`default_nettype wire

// ---- test/tb_rx_blanking_and_modulator_control.sv ----
// Self-checking bench for the blanking/modulator block
`timescale 1ns/100ps
`default_nettype none
`include "rbm_consts.svh"
module tb_rx_blanking_and_modulator_control;
  logic clk = 0, nrst = 0, psel = 0, pen = 0, pwr = 0, chip_en = 1, eof = 0, txm = 0;
  logic req_ook = 0, mod_lvl = 0, ana = 0, h_out, h_oe, h_mod, pin;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwd = 32'h0, prd, rd;
  logic rdy, err, e, rxr, sclk, p_out, p_oe, ook, msig;
  logic [2:0] dep;
  int num_errors = 0, cmp_count = 0, cyc = 0;
  localparam int STEP = `RBM_BLANK_STEP_CYC;
  always #20 clk = ~clk;
  // Device wins the shared pin while its enable is high
  // Weak pull-down while neither side drives, e.g. in the cycle after a hand-over
  assign pin = p_oe ? p_out : (h_oe ? h_out : 1'b0);
  rbm_ctrl rbm_ctrl_inst (.system_clock_output_in(clk), .nrst_in(nrst), .ce_in(1'b1), .paddr_in(paddr), .psel_in(psel),
    .penable_in(pen), .pwrite_in(pwr), .pwdata_in(pwd), .chip_enable_in(chip_en), .tx_eof_end_in(eof),
    .tx_mod_in(txm), .ask_ook_pin_in(pin), .modulation_input_pin_in(h_mod), .analog_subcarrier_in(ana),
    .prdata_out(prd), .pready_out(rdy), .pslverr_out(err), .rx_decoder_reset_out(rxr),
    .system_clock_output_out(sclk), .ask_ook_pin_out(p_out), .ask_ook_pin_oe_out(p_oe),
    .mod_depth_out(dep), .ook_active_out(ook), .mod_signal_out(msig));
  rbm_host_model rbm_host_model_inst (.clk_in(clk), .nrst_in(nrst), .req_ook_in(req_ook), .mod_level_in(mod_lvl),
    .dev_oe_in(p_oe), .ook_pin_out(h_out), .ook_pin_oe_out(h_oe), .mod_pin_out(h_mod));
  task automatic results();
    $display("errors %0d compares %0d", num_errors, cmp_count);
    if (num_errors == 0 && cmp_count > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      num_errors++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic wt(input int n);
    repeat (n) @(posedge clk);
  endtask
  // Holds the request until pready is seen high, then releases at that edge
  task automatic apb(input logic w, input logic [5:0] idx, input logic [31:0] wd);
    @(posedge clk);
    psel <= 1; pen <= 0; pwr <= w; paddr <= {idx, 2'b00}; pwd <= wd;
    @(posedge clk);
    pen <= 1;
    // Only the bench timeout ends a wait that never sees pready
    do @(posedge clk); while (rdy !== 1'b1);
    rd = prd;
    e = err;
    psel <= 0; pen <= 0;
  endtask
  task automatic pulse();
    @(posedge clk);
    eof <= 1;
    @(posedge clk);
    eof <= 0;
  endtask
  task automatic t_reset();
    apb(0, `RBM_IDX_BLANK, 0); chk("blank_rst", rd, 32'h1F);
    apb(0, `RBM_IDX_MODCTL, 0); chk("mod_rst", rd, 32'h11);
    apb(0, 6'h3F, 0); chk("unmapped", {e, rd[30:0]}, 32'h80000000);
    apb(1, `RBM_IDX_BLANK, 32'hA5); apb(0, `RBM_IDX_BLANK, 0); chk("blank_rw", rd, 32'hA5);
  endtask
  task automatic t_blank();
    int n;
    apb(1, `RBM_IDX_BLANK, 32'h02);
    pulse(); wt(300); pulse();
    n = 0;
    repeat (2 * STEP + 20) begin
      @(negedge clk);
      if (rxr === 1'b1) n++;
    end
    chk("blank_len", n, 2 * STEP);
    pulse(); wt(5);
    chk("blank_on", rxr, 1);
    apb(1, `RBM_IDX_BLANK, 32'h00); pulse(); wt(2);
    chk("blank_cut", rxr, 0);
    pulse(); wt(2);
    chk("blank_zero", rxr, 0);
  endtask
  task automatic t_preset();
    logic [7:0] pre [4] = '{8'h1F, 8'h07, 8'h01, 8'h07};
    apb(1, `RBM_IDX_MODCTL, 32'h7F);
    for (int f = 0; f < 4; f++) begin
      apb(1, `RBM_IDX_PROTO, f);
      apb(0, `RBM_IDX_BLANK, 0); chk("preset", rd, pre[f]);
      apb(0, `RBM_IDX_MODCTL, 0); chk("mod_keep", rd, 32'h31);
    end
  endtask
  task automatic t_clk();
    int n, ex;
    logic pv;
    for (int c = 0; c < 4; c++) begin
      apb(1, `RBM_IDX_MODCTL, c << 4); wt(4);
      n = 0; pv = sclk; ex = c ? (4 << c) : 0;
      repeat (64) begin
        @(negedge clk);
        if (sclk === 1'b1 && pv === 1'b0) n++;
        pv = sclk;
      end
      chk("clk_rises", (n >= ex - 1 && n <= ex), 1);
    end
  endtask
  task automatic t_depth();
    for (int d = 0; d < 8; d++) begin
      apb(1, `RBM_IDX_MODCTL, d); wt(3);
      chk("depth", dep, d);
      chk("ook", ook, d == 1);
    end
    txm <= 1; wt(3); chk("mod_int", msig, 1);
    txm <= 0; wt(3); chk("mod_int0", msig, 0);
  endtask
  task automatic t_ext();
    apb(1, `RBM_IDX_PROTO, 32'h00); apb(1, `RBM_IDX_MODCTL, 32'h44);
    req_ook <= 1; wt(6); chk("ext_off", ook, 0);
    apb(1, `RBM_IDX_PROTO, 32'h40); apb(1, `RBM_IDX_MODCTL, 32'h44); wt(6);
    chk("ext_ook", ook, 1);
    apb(0, `RBM_IDX_STATUS, 0); chk("status", rd, 32'h00000001);
    req_ook <= 0; wt(6); chk("ext_ask", {ook, dep}, 4'h4);
    mod_lvl <= 1; wt(6); chk("ext_mod", msig, 1);
    mod_lvl <= 0; wt(6); chk("ext_mod0", msig, 0);
  endtask
  task automatic t_ana();
    apb(1, `RBM_IDX_MODCTL, 32'h08); wt(4); chk("ana_oe", p_oe, 1);
    ana <= 1; wt(5); chk("ana_hi", p_out, 1);
    ana <= 0; wt(5); chk("ana_lo", p_out, 0);
    apb(1, `RBM_IDX_MODCTL, 32'h00); wt(4); chk("ana_off", p_oe, 0);
  endtask
  task automatic t_chip();
    apb(1, `RBM_IDX_BLANK, 32'h55); apb(1, `RBM_IDX_MODCTL, 32'h22);
    chip_en <= 0; wt(6); apb(1, `RBM_IDX_BLANK, 32'h66);
    chip_en <= 1; wt(4);
    apb(0, `RBM_IDX_BLANK, 0); chk("en_blank", rd, 32'h1F);
    apb(0, `RBM_IDX_MODCTL, 0); chk("en_mod", rd, 32'h11);
  endtask
  // Cut short a hung run
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      num_errors++;
      results();
    end
  end
  initial begin
    wt(10);
    nrst <= 1;
    wt(4);
    t_reset(); t_blank(); t_preset(); t_clk(); t_depth(); t_ext(); t_ana(); t_chip();
    results();
  end
endmodule
`default_nettype wire
